// File: rtl/scm_clock_control.v
// System clock selection and operating mode control with Wishbone registers.
`timescale 1ns/1ps
`include "scm_regs.vh"
// Overview of the block.
// Two oscillator models feed this controller: a fast one whose frequency
// code is stored in the fast oscillator control register, and a slow one
// that never stops. Neither oscillator is modelled as a real clock here.
// The whole block runs on CLK, and every clock that it hands to the rest of
// the device is expressed as an enable level or an enable pulse train.
// The system clock enable is a pulse train: in fast mode it comes from the
// divider, one pulse every two to the n cycles for select code n, and in
// slow mode it follows the sub clock enable level.
// The mode register holds one of six operating modes. Only the two running
// modes switch mode on the select field; the four CPU-off modes are entered
// from a halt pulse and are left only through the wake input.
// The keep bits are read in the cycle of the halt pulse, so software may
// rewrite them while the CPU is off without moving the current mode.
// The stable flag models oscillator start-up with a plain counter. It is a
// parameter because the real start-up time depends on the analog part; the
// bench uses a short value so that its runs stay brief.
// Limitation: the divider counts CLK edges, not real fast oscillator edges,
// so the enable rate scales with CLK and not with the chosen frequency.
// Trade-off: gating is decided from registered state only (mode, select field, enable bit), which costs
// one cycle of latency after a halt but keeps every enable glitch free.
module scm_clock_control #(
   parameter SETTLE_CYCLES = `SCM_SETTLE_CYC
) (
   input wire CLK,
   input wire RST,
   input wire [7:0] WB_ADR_I,
   input wire [31:0] WB_DAT_I,
   output reg [31:0] WB_DAT_O,
   input wire WB_WE_I,
   input wire [3:0] WB_SEL_I,
   input wire WB_CYC_I,
   input wire WB_STB_I,
   output reg WB_ACK_O,
   input wire HALT,
   input wire WAKE,
   output wire CPU_RUN,
   output wire SYS_CLK_EN,
   output wire HIGH_CLK_ON,
   output wire SUB_CLK_ON,
   output wire SLOW_OSC_ON,
   output wire WDT_CLK_ON,
   output wire TIMEBASE_CLK_ON,
   output wire [1:0] FAST_FREQ,
   output wire [2:0] MODE
);
   // System clock control register fields.
   reg [2:0] sys_clk_select;
   reg high_keep_in_halt;
   reg low_keep_in_halt;
   // Fast oscillator control register fields.
   reg [1:0] fast_freq_select;
   reg fast_osc_enable;
   reg fast_osc_stable_flag;
   // Frequency actually delivered by the fast oscillator.
   reg [1:0] fast_freq_active;
   // Settling counter for the fast oscillator.
   reg [15:0] settle_count;
   // Operating mode state and its next value.
   reg [2:0] mode;
   reg [2:0] next_mode;
   // Bus request qualified for this cycle.
   wire bus_req;
   wire wr_lane0;
   // Tick from the high clock divider.
   wire div_tick;
   // Clock gating terms.
   reg high_on;
   reg sub_on;
   reg sys_on;
   // Reset images of the two control registers, split into fields below.
   // Holding them as bytes keeps each field assignment at its own width.
   wire [7:0] sys_ctrl_init;
   wire [7:0] fast_ctrl_init;

   assign sys_ctrl_init = `SCM_SYS_CTRL_RESET;
   assign fast_ctrl_init = `SCM_FAST_CTRL_RESET;

   assign bus_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
   assign wr_lane0 = bus_req & WB_WE_I & WB_SEL_I[0];

   // Map the frequency code; code 11 falls back to the lowest setting.
   function [1:0] freq_decode;
      input [1:0] code;
      begin
         if (code == 2'h3) begin
            freq_decode = `SCM_FREQ_2M;
         end else begin
            freq_decode = code;
         end
      end
   endfunction

   // Classify the halt keep bits into a CPU-off mode.
   function [2:0] halt_mode;
      input keep_high;
      input keep_low;
      begin
         case ({keep_high, keep_low})
            2'b00: halt_mode = `SCM_MODE_SLEEP;
            2'b01: halt_mode = `SCM_MODE_IDLE_LOW;
            2'b11: halt_mode = `SCM_MODE_IDLE_DUAL;
            default: halt_mode = `SCM_MODE_IDLE_HIGH;
         endcase
      end
   endfunction

   // Register writes; only byte lane 0 holds data, upper lanes are ignored.
   always @(posedge CLK) begin
      if (RST) begin
         // Each field takes its slice of the register's reset image.
         sys_clk_select <= sys_ctrl_init[`SCM_SEL_HI:`SCM_SEL_LO];
         high_keep_in_halt <= sys_ctrl_init[`SCM_KEEP_HIGH];
         low_keep_in_halt <= sys_ctrl_init[`SCM_KEEP_LOW];
         fast_freq_select <= fast_ctrl_init[`SCM_FREQ_HI:`SCM_FREQ_LO];
         fast_osc_enable <= fast_ctrl_init[`SCM_ENABLE_BIT];
      end else if (wr_lane0) begin
         if (WB_ADR_I == `SCM_ADDR_SYS_CTRL) begin
            // Bits 4 to 2 are not stored.
            sys_clk_select <= WB_DAT_I[`SCM_SEL_HI:`SCM_SEL_LO];
            high_keep_in_halt <= WB_DAT_I[`SCM_KEEP_HIGH];
            low_keep_in_halt <= WB_DAT_I[`SCM_KEEP_LOW];
         end else if (WB_ADR_I == `SCM_ADDR_FAST_CTRL) begin
            fast_freq_select <= WB_DAT_I[`SCM_FREQ_HI:`SCM_FREQ_LO];
            fast_osc_enable <= WB_DAT_I[`SCM_ENABLE_BIT];
         end
      end
   end

   // Settling of the fast oscillator. Disabling it or changing its frequency
   // clears the stable flag; the new frequency is applied only once settled.
   // The counter stands in for the analog start-up, so it is a parameter.
   always @(posedge CLK) begin
      if (RST) begin
         settle_count <= 16'h0000;
         fast_osc_stable_flag <= 1'b0;
         fast_freq_active <= `SCM_FREQ_2M;
      end else if (!fast_osc_enable || !high_on) begin
         settle_count <= 16'h0000;
         fast_osc_stable_flag <= 1'b0;
      end else if (freq_decode(fast_freq_select) != fast_freq_active &&
                   fast_osc_stable_flag) begin
         settle_count <= 16'h0000;
         fast_osc_stable_flag <= 1'b0;
      end else if (!fast_osc_stable_flag) begin
         if (settle_count >= SETTLE_CYCLES[15:0] - 16'h0001) begin
            fast_osc_stable_flag <= 1'b1;
            fast_freq_active <= freq_decode(fast_freq_select);
         end else begin
            settle_count <= settle_count + 16'h0001;
         end
      end
   end

   // Mode next state: select field steers fast and slow, halt samples keeps.
   always @* begin
      next_mode = mode;
      case (mode)
         `SCM_MODE_FAST, `SCM_MODE_SLOW: begin
            if (HALT) begin
               next_mode = halt_mode(high_keep_in_halt,
                                     low_keep_in_halt);
            end else if (sys_clk_select == `SCM_SEL_SUB) begin
               next_mode = `SCM_MODE_SLOW;
            end else begin
               next_mode = `SCM_MODE_FAST;
            end
         end
         `SCM_MODE_SLEEP, `SCM_MODE_IDLE_LOW, `SCM_MODE_IDLE_DUAL,
         `SCM_MODE_IDLE_HIGH: begin
            // Wake-up sequencing is outside this block; a wake simply returns.
            if (WAKE) begin
               if (sys_clk_select == `SCM_SEL_SUB) begin
                  next_mode = `SCM_MODE_SLOW;
               end else begin
                  next_mode = `SCM_MODE_FAST;
               end
            end
         end
         default: next_mode = `SCM_MODE_FAST;
      endcase
   end

   // Mode register.
   // A single register keeps the mode free of decoding glitches, so every
   // gating term below is derived from a settled value.
   always @(posedge CLK) begin
      if (RST) begin
         mode <= `SCM_MODE_FAST;
      end else begin
         mode <= next_mode;
      end
   end

   // Clock gating per mode.
   // Defaults leave every clock on, so an unexpected mode code fails safe
   // with the CPU clocks running rather than with the device stuck asleep.
   always @* begin
      high_on = 1'b1;
      sub_on = 1'b1;
      sys_on = 1'b1;
      case (mode)
         `SCM_MODE_FAST: begin
            high_on = 1'b1;
            sub_on = 1'b1;
         end
         `SCM_MODE_SLOW: begin
            // The high clock may keep running for peripherals.
            high_on = fast_osc_enable;
         end
         `SCM_MODE_SLEEP: begin
            high_on = 1'b0;
            sub_on = 1'b0;
            sys_on = 1'b0;
         end
         `SCM_MODE_IDLE_LOW: begin
            high_on = 1'b0;
            sys_on = (sys_clk_select == `SCM_SEL_SUB);
         end
         `SCM_MODE_IDLE_DUAL: begin
            sys_on = 1'b1;
         end
         `SCM_MODE_IDLE_HIGH: begin
            sub_on = 1'b0;
            sys_on = (sys_clk_select != `SCM_SEL_SUB);
         end
         default: begin
            high_on = 1'b1;
         end
      endcase
   end

   // Divider producing the fast system clock enable from the high clock.
   scm_divider #(
      .WIDTH(6)
   ) u_div (
      .clk(CLK),
      .rst(RST),
      .run(high_on),
      .ratio(sys_clk_select),
      .tick(div_tick)
   );

   // In slow selection the sub clock drives the system clock directly.
   assign SYS_CLK_EN = sys_on & ((sys_clk_select == `SCM_SEL_SUB) ?
                       sub_on : (div_tick & high_on));
   assign CPU_RUN = (mode == `SCM_MODE_FAST) | (mode == `SCM_MODE_SLOW);
   assign HIGH_CLK_ON = high_on;
   assign SUB_CLK_ON = sub_on;
   // The watchdog never stops, so its oscillator is held on in every mode.
   assign SLOW_OSC_ON = 1'b1;
   assign WDT_CLK_ON = SLOW_OSC_ON;
   assign TIMEBASE_CLK_ON = SLOW_OSC_ON | high_on;
   assign FAST_FREQ = fast_freq_active;
   assign MODE = mode;

   // Read data and acknowledge; unmapped reads return zero and still ack.
   // The acknowledge masks the request for one cycle, so a master that
   // still holds its strobe at the answering edge is never served twice.
   always @(posedge CLK) begin
      if (RST) begin
         WB_ACK_O <= 1'b0;
         WB_DAT_O <= 32'h00000000;
      end else begin
         WB_ACK_O <= bus_req;
         if (bus_req && !WB_WE_I) begin
            case (WB_ADR_I)
               `SCM_ADDR_SYS_CTRL: WB_DAT_O <= {24'h000000, sys_clk_select,
                  3'h0, high_keep_in_halt, low_keep_in_halt};
               `SCM_ADDR_FAST_CTRL: WB_DAT_O <= {28'h0000000,
                  fast_freq_select, fast_osc_stable_flag, fast_osc_enable};
               `SCM_ADDR_STATUS: WB_DAT_O <= {29'h00000000, mode};
               default: WB_DAT_O <= 32'h00000000;
            endcase
         end
      end
   end
endmodule

// File: rtl/scm_regs.vh
// Register offsets, field positions, reset values and timing for clock control.
`ifndef SCM_REGS_VH
`define SCM_REGS_VH
`define SCM_ADDR_SYS_CTRL 8'h00
`define SCM_ADDR_FAST_CTRL 8'h04
`define SCM_ADDR_STATUS 8'h08
`define SCM_SEL_HI 7
`define SCM_SEL_LO 5
`define SCM_KEEP_HIGH 1
`define SCM_KEEP_LOW 0
`define SCM_FREQ_HI 3
`define SCM_FREQ_LO 2
`define SCM_STABLE_BIT 1
`define SCM_ENABLE_BIT 0
`define SCM_SYS_CTRL_RESET 8'h00
`define SCM_FAST_CTRL_RESET 8'h01
`define SCM_SEL_SUB 3'h7
`define SCM_FREQ_2M 2'h0
`define SCM_FREQ_4M 2'h1
`define SCM_FREQ_8M 2'h2
`define SCM_SETTLE_NS 1000
`define SCM_CLK_NS 25
`define SCM_SETTLE_CYC ((`SCM_SETTLE_NS + `SCM_CLK_NS - 1) / `SCM_CLK_NS)
`define SCM_MODE_FAST 3'h0
`define SCM_MODE_SLOW 3'h1
`define SCM_MODE_SLEEP 3'h2
`define SCM_MODE_IDLE_LOW 3'h3
`define SCM_MODE_IDLE_DUAL 3'h4
`define SCM_MODE_IDLE_HIGH 3'h5
`endif

// File: rtl/scm_divider.v
// Ripple-free divider chain giving high clock enables divided by 1 to 64.
`timescale 1ns/1ps
module scm_divider #(
   parameter WIDTH = 6
) (
   input wire clk,
   input wire rst,
   input wire run,
   input wire [2:0] ratio,
   output reg tick
);
   // Free counter that advances while the high clock runs.
   reg [WIDTH-1:0] count;
   // Mask of counter bits that must be all ones for a tick.
   reg [WIDTH-1:0] mask;

   // Build the mask from the ratio code: codes n from 0 to 6 divide by two to the n, and code 7 divides by one.
   always @* begin
      mask = {WIDTH{1'b1}} >> (WIDTH - ratio);
   end

   // The tick is registered so the system clock enable has no glitches.
   always @(posedge clk) begin
      if (rst) begin
         count <= {WIDTH{1'b0}};
         tick <= 1'b0;
      end else if (run) begin
         count <= count + 1'b1;
         tick <= ((count & mask) == mask);
      end else begin
         tick <= 1'b0;
      end
   end
endmodule

// File: sim/scm_clock_control_props.sv
// Checker for bus timing and clock gating of the clock control block.
`timescale 1ns/1ps
module scm_clock_control_props #(
   parameter SETTLE_CYCLES = 40
) (
   input wire CLK,
   input wire RST,
   input wire WB_CYC_I,
   input wire WB_STB_I,
   input wire WB_ACK_O,
   input wire [31:0] WB_DAT_O,
   input wire HALT,
   input wire CPU_RUN,
   input wire SYS_CLK_EN,
   input wire HIGH_CLK_ON,
   input wire SUB_CLK_ON,
   input wire SLOW_OSC_ON,
   input wire WDT_CLK_ON,
   input wire TIMEBASE_CLK_ON,
   input wire [2:0] MODE
);
   // Everything here lives in the one clock domain.
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);
   chk_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
      else $error("ack held longer than one cycle");
   chk_ack_answer: assert property
      ((WB_CYC_I && WB_STB_I && !WB_ACK_O) |=> WB_ACK_O)
      else $error("request not answered next cycle");
   chk_upper_zero: assert property (WB_ACK_O |-> WB_DAT_O[31:8] == 24'h0)
      else $error("upper read bytes not zero");
   chk_slow_always: assert property
      (SLOW_OSC_ON && WDT_CLK_ON && TIMEBASE_CLK_ON)
      else $error("slow oscillator clock stopped");
   chk_run_modes: assert property (CPU_RUN == (MODE < 3'h2))
      else $error("cpu run disagrees with mode");
   chk_halt_enter: assert property ((HALT && CPU_RUN) |=> !CPU_RUN)
      else $error("halt did not stop the cpu");
   chk_fast_all: assert property
      (MODE == 3'h0 |-> HIGH_CLK_ON && SUB_CLK_ON)
      else $error("fast mode clock missing");
   chk_sleep_off: assert property
      (MODE == 3'h2 |-> !HIGH_CLK_ON && !SUB_CLK_ON && !SYS_CLK_EN)
      else $error("clock running in sleep");
   chk_idle_low: assert property
      (MODE == 3'h3 |-> !HIGH_CLK_ON && SUB_CLK_ON)
      else $error("low-only idle gating wrong");
   chk_idle_dual: assert property
      (MODE == 3'h4 |-> HIGH_CLK_ON && SUB_CLK_ON)
      else $error("dual idle gating wrong");
   chk_idle_high: assert property
      (MODE == 3'h5 |-> HIGH_CLK_ON && !SUB_CLK_ON)
      else $error("high-only idle gating wrong");
endmodule
bind scm_clock_control scm_clock_control_props
   #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_props (.*);

// File: sim/test_scm_clock_control.sv
// Bench for clock select, halt modes, oscillator control and bus access.
`timescale 1ns/1ps
`include "scm_regs.vh"
module test_scm_clock_control;
   logic clk = 0, rst = 1, we = 0, cyc = 0, stb = 0, halt = 0, wake = 0;
   logic [7:0] adr = 8'h00;
   logic [31:0] dat = 32'h0, rdat, q;
   logic [3:0] sel = 4'hF;
   logic ack, run, sys, hi, sub, slo, wdt, tb;
   logic [1:0] freq;
   logic [2:0] mode;
   int fail_count = 0, comparisons = 0, cyc_n = 0;
   always #12.5 clk = ~clk;
   // Settle of 8 keeps the cleared stable flag visible to a read.
   scm_clock_control #(.SETTLE_CYCLES(8)) DUT (.CLK(clk), .RST(rst),
      .WB_ADR_I(adr), .WB_DAT_I(dat), .WB_DAT_O(rdat), .WB_WE_I(we),
      .WB_SEL_I(sel), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_ACK_O(ack),
      .HALT(halt), .WAKE(wake), .CPU_RUN(run), .SYS_CLK_EN(sys),
      .HIGH_CLK_ON(hi), .SUB_CLK_ON(sub), .SLOW_OSC_ON(slo),
      .WDT_CLK_ON(wdt), .TIMEBASE_CLK_ON(tb), .FAST_FREQ(freq), .MODE(mode));
   task final_report;
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // A hung handshake must not stall the run forever.
   always @(posedge clk) begin
      cyc_n++;
      if (cyc_n > 20000) begin
         fail_count++;
         final_report;
      end
   end
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   // One classic cycle; data is taken at the edge that sees ack.
   task bus(input logic [7:0] a, input logic w, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1;
      stb <= 1;
      adr <= a;
      we <= w;
      dat <= {24'h0, d};
      // Only ack or the bench timeout ends this wait.
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1);
      q = rdat;
      chk("ack_wait", 2, n);
      cyc <= 0;
      stb <= 0;
      we <= 0;
   endtask
   task ticks(input int n, output int c);
      c = 0;
      repeat (n) begin
         @(posedge clk);
         c += (sys === 1'b1);
      end
   endtask
   task t_reset;
      bus(`SCM_ADDR_SYS_CTRL, 0, 0);
      chk("sys_ctrl", `SCM_SYS_CTRL_RESET, q);
      chk("mode", `SCM_MODE_FAST, mode);
      repeat (12) @(posedge clk);
      bus(`SCM_ADDR_FAST_CTRL, 0, 0);
      chk("fast_ctrl", 32'h3, q);
      bus(8'h0C, 1, 8'hFF);
      bus(8'h0C, 0, 0);
      chk("unmapped", 0, q);
      bus(`SCM_ADDR_SYS_CTRL, 1, 8'hFF);
      bus(`SCM_ADDR_SYS_CTRL, 0, 0);
      chk("unused_bits", 32'hE3, q);
      $display("test reset done");
   endtask
   task t_select;
      int c;
      for (int s = 0; s < 8; s++) begin
         bus(`SCM_ADDR_SYS_CTRL, 1, 8'(s << 5));
         repeat (4) @(posedge clk);
         chk("mode", s == 7 ? 1 : 0, mode);
         if (s < 7) begin
            ticks(128, c);
            chk("sys_ticks", 128 >> s, c);
         end
      end
      // Slow mode: the high clock follows its enable bit alone.
      bus(`SCM_ADDR_FAST_CTRL, 1, 8'h00);
      repeat (2) @(posedge clk);
      chk("high_off", 0, hi);
      chk("sub_on", 1, sub);
      bus(`SCM_ADDR_FAST_CTRL, 1, 8'h01);
      repeat (12) @(posedge clk);
      chk("high_on", 1, hi);
      $display("test select done");
   endtask
   task t_halt;
      logic [2:0] em [4] = '{3'h2, 3'h3, 3'h5, 3'h4};
      int c, s, k;
      for (int i = 0; i < 8; i++) begin
         s = i[2] ? 7 : 0;
         k = i & 3;
         bus(`SCM_ADDR_SYS_CTRL, 1, 8'(s << 5 | k));
         repeat (4) @(posedge clk);
         halt <= 1;
         @(posedge clk);
         halt <= 0;
         // Flipping the keep bits now must not move the mode.
         bus(`SCM_ADDR_SYS_CTRL, 1, 8'(s << 5 | (k ^ 3)));
         chk("mode", em[k], mode);
         chk("cpu_run", 0, run);
         chk("high_on", k[1], hi);
         chk("sub_on", k[0], sub);
         chk("slow_osc", 3'h7, {slo, wdt, tb});
         ticks(64, c);
         chk("sys_runs", s == 7 ? k[0] : k[1], c != 0);
         wake <= 1;
         @(posedge clk);
         wake <= 0;
         repeat (2) @(posedge clk);
         chk("wake_mode", s == 7 ? 1 : 0, mode);
      end
      $display("test halt done");
   endtask
   task t_freq;
      logic [1:0] ef [4] = '{2'h0, 2'h1, 2'h2, 2'h0};
      // Each step changes the decoded frequency, so each must re-settle.
      logic [1:0] fo [4] = '{2'h2, 2'h3, 2'h1, 2'h0};
      logic [1:0] old;
      int f;
      for (int i = 0; i < 4; i++) begin
         f = fo[i];
         old = freq;
         bus(`SCM_ADDR_FAST_CTRL, 1, 8'(f << 2 | 1));
         bus(`SCM_ADDR_FAST_CTRL, 0, 0);
         chk("unstable", 8'(f << 2 | 1), q);
         chk("freq_hold", old, freq);
         repeat (20) @(posedge clk);
         chk("freq", ef[f], freq);
         bus(`SCM_ADDR_FAST_CTRL, 0, 0);
         chk("stable", 8'(f << 2 | 3), q);
      end
      $display("test freq done");
   endtask
   initial begin
      repeat (12) @(posedge clk);
      rst <= 0;
      t_reset;
      t_select;
      t_halt;
      t_freq;
      final_report;
   end
endmodule
